// ---- logic/wake_timer_pkg.sv ----
`default_nettype none

// ----------------------------------------------------------------------------
// Wake-up timer constants
// ----------------------------------------------------------------------------
package wake_timer_pkg;

   // Bus and datapath widths
   localparam int unsigned ADDR_W = 32;  // APB address width
   localparam int unsigned DATA_W = 32;  // APB data width
   localparam int unsigned HALF_W = 16;  // Width of each register
   localparam int unsigned CNT_W  = 32;  // Counter width
   localparam int unsigned NUM_CMP = 3;  // Compare channels A, B, C

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_COUNTER_LOW  = 32'h4000_2500;  // Counter bits 15:0, read only
   localparam logic [ADDR_W-1:0] OFS_COUNTER_HIGH = 32'h4000_2504;  // Counter bits 31:16, read only
   localparam logic [ADDR_W-1:0] OFS_CONTROL      = 32'h4000_2508;  // Mode control
   localparam logic [ADDR_W-1:0] OFS_ENABLE       = 32'h4000_250C;  // Timer enable
   localparam logic [ADDR_W-1:0] OFS_CMP_A_LOW    = 32'h4000_2510;  // Compare A bits 15:0
   localparam logic [ADDR_W-1:0] OFS_CMP_A_HIGH   = 32'h4000_2514;  // Compare A bits 31:16
   localparam logic [ADDR_W-1:0] OFS_CMP_B_LOW    = 32'h4000_2518;  // Compare B bits 15:0
   localparam logic [ADDR_W-1:0] OFS_CMP_B_HIGH   = 32'h4000_251C;  // Compare B bits 31:16
   localparam logic [ADDR_W-1:0] OFS_CMP_C_LOW    = 32'h4000_2520;  // Compare C bits 15:0
   localparam logic [ADDR_W-1:0] OFS_CMP_C_HIGH   = 32'h4000_2524;  // Compare C bits 31:16
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE   = 32'h4000_2528;  // Interrupt and compare enables
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS   = 32'h4000_252C;  // Sticky flags, read only
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR    = 32'h4000_2530;  // Write one to clear a flag
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK     = 32'h4000_2534;  // Gates flags onto the irq pin
   localparam logic [ADDR_W-1:0] CMP_STRIDE       = 32'h0000_0008;  // Distance between channels

   // Reset values
   localparam logic [HALF_W-1:0] RST_CMP_A_LOW = 16'h1FFF;  // Compare A low half
   localparam logic [HALF_W-1:0] RST_CMP_B_LOW = 16'h2FFF;  // Compare B low half
   localparam logic [HALF_W-1:0] RST_CMP_C_LOW = 16'h3FFF;  // Compare C low half
   localparam logic [HALF_W-1:0] RST_CMP_HIGH  = 16'h0000;  // All high halves
   localparam logic [3:0]        RST_IRQ_EN    = 4'h0;      // Interrupt enables
   localparam logic [3:0]        RST_IRQ_MASK  = 4'h0;      // Interrupt mask
   localparam logic [CNT_W-1:0]  CNT_ZERO      = 32'h0000_0000;  // Up-count start
   localparam logic [CNT_W-1:0]  CNT_FULL      = 32'hFFFF_FFFF;  // Down-count start

   // Field positions
   localparam int unsigned EN_BIT        = 0;  // Timer enable in enable register
   localparam int unsigned CTRL_DOWN_BIT = 2;  // Count down when set
   localparam int unsigned CTRL_FREE_BIT = 4;  // Free running when set
   localparam int unsigned IRQ_A_BIT     = 0;  // Compare A enable and flag
   localparam int unsigned IRQ_B_BIT     = 1;  // Compare B enable and flag
   localparam int unsigned IRQ_C_BIT     = 2;  // Compare C enable and flag
   localparam int unsigned IRQ_ROLL_BIT  = 3;  // Rollover enable and flag
   localparam int unsigned STA_SYNC_BIT  = 8;  // Enable change still in flight

endpackage

`default_nettype wire

// ---- logic/wake_timer_compare_irq.sv ----
`default_nettype none

module wake_timer_compare_irq (
   input  wire logic                                pclk,         // APB clock, 100 MHz
   input  wire logic                                presetn,      // Async reset, active low
   input  wire logic                                psel,         // APB select
   input  wire logic                                penable,      // APB access phase
   input  wire logic                                pwrite,       // APB direction, high = write
   input  wire logic [wake_timer_pkg::ADDR_W-1:0]   paddr,        // APB byte address
   input  wire logic [wake_timer_pkg::DATA_W-1:0]   pwdata,       // APB write data
   output logic      [wake_timer_pkg::DATA_W-1:0]   prdata,       // APB read data
   output logic                                     pready,       // APB ready
   output logic                                     pslverr,      // APB error, unmapped address
   input  wire logic                                lf_tick_pin,  // 32.768 kHz counting clock pin
   output logic                                     wake_irq      // Level interrupt, active high
);
   import wake_timer_pkg::*;

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic [HALF_W-1:0]  cmp_lo_ff [NUM_CMP];  // Compare low halves A, B, C
   logic [HALF_W-1:0]  cmp_hi_ff [NUM_CMP];  // Compare high halves A, B, C
   logic [CNT_W-1:0]   cmp_full  [NUM_CMP];  // Joined 32-bit compare values
   logic               enable_ff;            // Software enable bit
   logic               run_ff;               // Enable as seen by the tick domain
   logic               sync_busy_ff;         // Enable change not yet applied
   logic               free_ff;              // Free running mode
   logic               down_ff;              // Count down mode
   logic [3:0]         irq_en_ff;            // Compare and rollover enables
   logic [3:0]         irq_mask_ff;          // Interrupt output mask
   logic [3:0]         irq_sta_ff;           // Sticky event flags
   logic [CNT_W-1:0]   cnt_ff;               // Counter
   logic [CNT_W-1:0]   nxt_cnt;              // Next counter value
   logic [CNT_W-1:0]   start_val;            // Counter value after a restart
   logic [3:0]         event_set;            // Events setting flags this cycle
   logic               tick_meta_ff;         // Synchroniser first stage
   logic               tick_sync_ff;         // Synchroniser second stage
   logic               tick_prev_ff;         // Previous synchronised level
   logic               tick;                 // One pulse per counting clock edge
   logic               wr_en;                // APB write takes effect
   logic               rd_en;                // APB read access
   logic               mapped;               // Address hits a register
   logic               enable_change;        // Write flips the enable bit
   logic               period_end;           // Periodic count reached compare C
   logic               wrap;                 // Free running count wraps

   // -------------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------------
   // Exact word match; used for every register in both write and read paths
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      return addr == ofs;
   endfunction

   // Zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign mapped  = hit(paddr, OFS_COUNTER_LOW) | hit(paddr, OFS_COUNTER_HIGH) | hit(paddr, OFS_CONTROL)
                  | hit(paddr, OFS_ENABLE) | hit(paddr, OFS_CMP_A_LOW) | hit(paddr, OFS_CMP_A_HIGH)
                  | hit(paddr, OFS_CMP_B_LOW) | hit(paddr, OFS_CMP_B_HIGH) | hit(paddr, OFS_CMP_C_LOW)
                  | hit(paddr, OFS_CMP_C_HIGH) | hit(paddr, OFS_IRQ_ENABLE) | hit(paddr, OFS_IRQ_STATUS)
                  | hit(paddr, OFS_IRQ_CLEAR) | hit(paddr, OFS_IRQ_MASK);
   // Unmapped accesses answer with an error and change nothing
   assign pslverr = psel & penable & ~mapped;

   // -------------------------------------------------------------------------
   // Counting clock synchroniser
   // -------------------------------------------------------------------------
   // The pin is asynchronous; only the second stage and its delayed copy are looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_meta_ff <= 1'b0;
         tick_sync_ff <= 1'b0;
         tick_prev_ff <= 1'b0;
      end else begin
         tick_meta_ff <= lf_tick_pin;
         tick_sync_ff <= tick_meta_ff;
         tick_prev_ff <= tick_sync_ff;
      end
   end

   // Rising edge of the counting clock
   assign tick = tick_sync_ff & ~tick_prev_ff;

   // -------------------------------------------------------------------------
   // Compare registers
   // -------------------------------------------------------------------------
   // Upper 16 bits of write data are dropped; software keeps them zero
   generate
      for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
         localparam logic [ADDR_W-1:0] OFS_LO = OFS_CMP_A_LOW + ADDR_W'(g) * CMP_STRIDE;
         localparam logic [ADDR_W-1:0] OFS_HI = OFS_CMP_A_HIGH + ADDR_W'(g) * CMP_STRIDE;
         localparam logic [HALF_W-1:0] RST_LO = (g == 0) ? RST_CMP_A_LOW : (g == 1) ? RST_CMP_B_LOW : RST_CMP_C_LOW;

         // Each half written on its own word
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cmp_lo_ff[g] <= RST_LO;
               cmp_hi_ff[g] <= RST_CMP_HIGH;
            end else if (wr_en) begin
               if (hit(paddr, OFS_LO)) begin
                  cmp_lo_ff[g] <= pwdata[HALF_W-1:0];
               end
               if (hit(paddr, OFS_HI)) begin
                  cmp_hi_ff[g] <= pwdata[HALF_W-1:0];
               end
            end
         end

         // High half in the upper bits
         assign cmp_full[g] = {cmp_hi_ff[g], cmp_lo_ff[g]};
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Control, enable, interrupt enable and mask registers
   // -------------------------------------------------------------------------
   // Mode bits are not guarded; changing them while running is software's hazard
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         free_ff     <= 1'b0;
         down_ff     <= 1'b0;
         enable_ff   <= 1'b0;
         irq_en_ff   <= RST_IRQ_EN;
         irq_mask_ff <= RST_IRQ_MASK;
      end else if (wr_en) begin
         if (hit(paddr, OFS_CONTROL)) begin
            free_ff <= pwdata[CTRL_FREE_BIT];
            down_ff <= pwdata[CTRL_DOWN_BIT];
         end
         if (hit(paddr, OFS_ENABLE)) begin
            enable_ff <= pwdata[EN_BIT];
         end
         if (hit(paddr, OFS_IRQ_ENABLE)) begin
            irq_en_ff <= pwdata[3:0];
         end
         if (hit(paddr, OFS_IRQ_MASK)) begin
            irq_mask_ff <= pwdata[3:0];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Enable hand-over into the counting domain
   // -------------------------------------------------------------------------
   assign enable_change = wr_en & hit(paddr, OFS_ENABLE) & (pwdata[EN_BIT] != enable_ff);

   // Enable reaches the counter only on a counting edge, as in the slow domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 1'b0;
      end else if (tick) begin
         run_ff <= enable_ff;
      end
   end

   // Busy from the write until the next counting edge; a new change wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_busy_ff <= 1'b0;
      end else if (enable_change) begin
         sync_busy_ff <= 1'b1;
      end else if (tick) begin
         sync_busy_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------------------
   // Next value: held at start while disabled, steps once per counting edge
   always_comb begin
      start_val  = down_ff ? CNT_FULL : CNT_ZERO;
      period_end = ~free_ff & (cnt_ff == cmp_full[2]);
      wrap       = free_ff & (cnt_ff == (down_ff ? CNT_ZERO : CNT_FULL));
      nxt_cnt    = cnt_ff;
      if (!run_ff) begin
         nxt_cnt = start_val;
      end else if (tick) begin
         if (period_end) begin
            nxt_cnt = start_val;
         end else if (down_ff) begin
            nxt_cnt = cnt_ff - 32'h0000_0001;
         end else begin
            nxt_cnt = cnt_ff + 32'h0000_0001;
         end
      end
   end

   // Counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= CNT_ZERO;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // -------------------------------------------------------------------------
   // Events and sticky flags
   // -------------------------------------------------------------------------
   // A compare only sets its flag while its enable is set, so clearing the enable
   // around a half-written update keeps a stale value from raising a flag
   generate
      for (genvar g = 0; g < NUM_CMP; g++) begin : g_evt
         assign event_set[g] = run_ff & tick & irq_en_ff[g] & (nxt_cnt == cmp_full[g]);
      end
   endgenerate

   // Rollover counts only in free running mode
   assign event_set[IRQ_ROLL_BIT] = run_ff & tick & wrap & irq_en_ff[IRQ_ROLL_BIT];

   // Set beats a clear in the same cycle so no event is lost
   generate
      for (genvar g = 0; g < 4; g++) begin : g_sta
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_sta_ff[g] <= 1'b0;
            end else if (event_set[g]) begin
               irq_sta_ff[g] <= 1'b1;
            end else if (wr_en & hit(paddr, OFS_IRQ_CLEAR) & pwdata[g]) begin
               irq_sta_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Level interrupt while any unmasked flag stands
   assign wake_irq = |(irq_sta_ff & irq_mask_ff);

   // -------------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------------
   // Reserved and write-only locations read as zero
   always_comb begin
      prdata = '0;
      if (rd_en) begin
         if (hit(paddr, OFS_COUNTER_LOW)) begin
            prdata[HALF_W-1:0] = cnt_ff[HALF_W-1:0];
         end else if (hit(paddr, OFS_COUNTER_HIGH)) begin
            prdata[HALF_W-1:0] = cnt_ff[CNT_W-1:HALF_W];
         end else if (hit(paddr, OFS_CONTROL)) begin
            prdata[CTRL_FREE_BIT] = free_ff;
            prdata[CTRL_DOWN_BIT] = down_ff;
         end else if (hit(paddr, OFS_ENABLE)) begin
            prdata[EN_BIT] = enable_ff;
         end else if (hit(paddr, OFS_CMP_A_LOW)) begin
            prdata[HALF_W-1:0] = cmp_lo_ff[0];
         end else if (hit(paddr, OFS_CMP_A_HIGH)) begin
            prdata[HALF_W-1:0] = cmp_hi_ff[0];
         end else if (hit(paddr, OFS_CMP_B_LOW)) begin
            prdata[HALF_W-1:0] = cmp_lo_ff[1];
         end else if (hit(paddr, OFS_CMP_B_HIGH)) begin
            prdata[HALF_W-1:0] = cmp_hi_ff[1];
         end else if (hit(paddr, OFS_CMP_C_LOW)) begin
            prdata[HALF_W-1:0] = cmp_lo_ff[2];
         end else if (hit(paddr, OFS_CMP_C_HIGH)) begin
            prdata[HALF_W-1:0] = cmp_hi_ff[2];
         end else if (hit(paddr, OFS_IRQ_ENABLE)) begin
            prdata[3:0] = irq_en_ff;
         end else if (hit(paddr, OFS_IRQ_STATUS)) begin
            prdata[3:0]          = irq_sta_ff;
            prdata[STA_SYNC_BIT] = sync_busy_ff;
         end else if (hit(paddr, OFS_IRQ_MASK)) begin
            prdata[3:0] = irq_mask_ff;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   // Held disabled over two cycles, the counter sits at its start value
   property p_disabled_holds;
      @(posedge pclk) disable iff (!presetn)
      (!run_ff ##1 !run_ff) |-> (cnt_ff == ($past(down_ff) ? CNT_FULL : CNT_ZERO));
   endproperty
   a_disabled_holds: assert property (p_disabled_holds) else $error("counter not at start while disabled");

   // Out of reset the compare halves carry their documented values
   property p_cmp_reset;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (cmp_full[0] == 32'h0000_1FFF) && (cmp_full[1] == 32'h0000_2FFF)
                         && (cmp_full[2] == 32'h0000_3FFF);
   endproperty
   a_cmp_reset: assert property (p_cmp_reset) else $error("compare reset value wrong");

   // Periodic up count at compare C restarts from zero on the counting edge
   property p_period_restart;
      @(posedge pclk) disable iff (!presetn)
      (run_ff && tick && !free_ff && !down_ff && cnt_ff == cmp_full[2]) |=> (cnt_ff == CNT_ZERO);
   endproperty
   a_period_restart: assert property (p_period_restart) else $error("periodic count did not restart");

   // No compare flag rises unless its enable and a counting edge stood
   property p_flag_needs_enable;
      @(posedge pclk) disable iff (!presetn)
      (irq_sta_ff[2:0] & ~$past(irq_sta_ff[2:0]) & ~($past(irq_en_ff[2:0]) & {3{$past(tick)}})) == 3'h0;
   endproperty
   a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("flag set with enable clear");

   // Rollover flag rises only in free running mode
   property p_roll_free_only;
      @(posedge pclk) disable iff (!presetn)
      $rose(irq_sta_ff[IRQ_ROLL_BIT]) |-> $past(free_ff) && $past(irq_en_ff[IRQ_ROLL_BIT]);
   endproperty
   a_roll_free_only: assert property (p_roll_free_only) else $error("rollover flag outside free mode");

   // Enabled match on C sets its flag at the next edge
   property p_match_sets;
      @(posedge pclk) disable iff (!presetn)
      (run_ff && tick && irq_en_ff[IRQ_C_BIT] && nxt_cnt == cmp_full[2]) |=> irq_sta_ff[IRQ_C_BIT];
   endproperty
   a_match_sets: assert property (p_match_sets) else $error("compare C match lost");

   // No interrupt enable is set right out of reset
   property p_ien_reset;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (irq_en_ff == 4'h0) && !wake_irq;
   endproperty
   a_ien_reset: assert property (p_ien_reset) else $error("interrupt enable not zero after reset");

   // A flip of the enable bit shows busy until a counting edge applies it
   property p_sync_flag;
      @(posedge pclk) disable iff (!presetn)
      (enable_change |=> sync_busy_ff) and (tick && !enable_change |=> !sync_busy_ff && run_ff == $past(enable_ff));
   endproperty
   a_sync_flag: assert property (p_sync_flag) else $error("enable sync flag wrong");

   // A standing compare A flag stays until cleared by a one on the clear register
   property p_flag_sticky;
      @(posedge pclk) disable iff (!presetn)
      (irq_sta_ff[IRQ_A_BIT] && !(wr_en && hit(paddr, OFS_IRQ_CLEAR) && pwdata[IRQ_A_BIT]))
      |=> irq_sta_ff[IRQ_A_BIT];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

   // A compare A flag rise means the whole counter equalled high:low of compare A
   property p_full_match;
      @(posedge pclk) disable iff (!presetn)
      $rose(irq_sta_ff[IRQ_A_BIT]) |-> (cnt_ff == {$past(cmp_hi_ff[0]), $past(cmp_lo_ff[0])});
   endproperty
   a_full_match: assert property (p_full_match) else $error("match not on full compare value");

endmodule

`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench for the wake-up compare and interrupt block
// ----------------------------------------------------------------
module tb import wake_timer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite;  // Bus controls
   logic        lf_tick_pin;                          // Counting pin
   logic [31:0] paddr, pwdata, prdata, rv;            // Bus data, last read
   logic        pready, pslverr, wake_irq, re;        // Outputs, last error
   int          n_fail, num_checks;                   // Tallies
   logic [31:0] rst_addr [8] = '{OFS_CMP_A_LOW, OFS_CMP_A_HIGH, OFS_CMP_B_LOW, OFS_CMP_B_HIGH,
                                 OFS_CMP_C_LOW, OFS_CMP_C_HIGH, OFS_IRQ_ENABLE, OFS_IRQ_STATUS};
   logic [15:0] rst_val [8] = '{16'h1FFF, 16'h0000, 16'h2FFF, 16'h0000, 16'h3FFF, 16'h0000, 16'h0000, 16'h0000};

   wake_timer_compare_irq wake_timer_compare_irq_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lf_tick_pin(lf_tick_pin), .wake_irq(wake_irq));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Verdict; the single exit of the run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer, then an idle cycle so no signal is driven twice in a step
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         $display("unexpected pready expected 1 seen %b", pready);
         report_and_stop();
      end
      rv = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, exp, rv);
   endtask

   // One counting edge, wide enough for the pin synchroniser
   task automatic tick();
      lf_tick_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      lf_tick_pin <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, lf_tick_pin} = 5'h00;
      {paddr, pwdata} = 64'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, OFS_IRQ_STATUS, 32'h0000_000F);  // Status is read only
      for (int i = 0; i < 8; i++) begin
         rd("reset value", rst_addr[i], {16'h0000, rst_val[i]});
      end
      chk("wake_irq", 32'h0, {31'h0, wake_irq});
      apb(1'b0, 32'h4000_2540, 32'h0000_0000);
      chk("pslverr", 32'h1, {31'h0, re});
      // Periodic up, C is the period; B left disabled though reachable
      apb(1'b1, OFS_CMP_C_LOW, 32'h0000_0005);
      apb(1'b1, OFS_CMP_A_LOW, 32'h0000_0002);
      apb(1'b1, OFS_CMP_B_LOW, 32'h0000_0003);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0005);
      apb(1'b1, OFS_ENABLE, 32'h0000_0001);
      rd("status", OFS_IRQ_STATUS, 32'h0000_0100);
      tick();
      rd("status", OFS_IRQ_STATUS, 32'h0000_0000);
      repeat (8) tick();
      rd("status", OFS_IRQ_STATUS, 32'h0000_0005);
      chk("wake_irq", 32'h0, {31'h0, wake_irq});
      rd("counter high", OFS_COUNTER_HIGH, 32'h0000_0000);
      rd("counter low", OFS_COUNTER_LOW, 32'h0000_0002);
      // Mask gates the pin; clear drops the sticky flags
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_000F);
      chk("wake_irq", 32'h1, {31'h0, wake_irq});
      apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0005);
      rd("status", OFS_IRQ_STATUS, 32'h0000_0000);
      chk("wake_irq", 32'h0, {31'h0, wake_irq});
      // A now differs only in the high half; rollover enabled in periodic mode
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0004);
      apb(1'b1, OFS_CMP_A_HIGH, 32'h0000_0001);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_000D);
      repeat (8) tick();
      rd("status", OFS_IRQ_STATUS, 32'h0000_0004);
      chk("wake_irq", 32'h1, {31'h0, wake_irq});
      // Disabling returns the counter to its reset state
      apb(1'b1, OFS_ENABLE, 32'h0000_0000);
      rd("status", OFS_IRQ_STATUS, 32'h0000_0104);
      tick();
      rd("status", OFS_IRQ_STATUS, 32'h0000_0004);
      rd("counter low", OFS_COUNTER_LOW, 32'h0000_0000);
      // Free running: C still flags but no longer restarts the count
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
      apb(1'b1, OFS_CMP_C_LOW, 32'h0000_0002);
      apb(1'b1, OFS_CONTROL, 32'h0000_0010);
      apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_000F);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0004);
      apb(1'b1, OFS_ENABLE, 32'h0000_0001);
      repeat (5) tick();
      rd("counter low", OFS_COUNTER_LOW, 32'h0000_0004);
      rd("status", OFS_IRQ_STATUS, 32'h0000_0004);
      // Periodic down: full scale down to C, then back to full scale
      apb(1'b1, OFS_ENABLE, 32'h0000_0000);
      tick();
      rd("status", OFS_IRQ_STATUS, 32'h0000_0004);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
      apb(1'b1, OFS_CMP_C_HIGH, 32'h0000_FFFF);
      apb(1'b1, OFS_CMP_C_LOW, 32'h0000_FFFC);
      apb(1'b1, OFS_CONTROL, 32'h0000_0004);
      rd("control", OFS_CONTROL, 32'h0000_0004);
      apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_000F);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0004);
      apb(1'b1, OFS_ENABLE, 32'h0000_0001);
      repeat (6) tick();
      rd("counter low", OFS_COUNTER_LOW, 32'h0000_FFFE);
      rd("counter high", OFS_COUNTER_HIGH, 32'h0000_FFFF);
      rd("status", OFS_IRQ_STATUS, 32'h0000_0004);
      report_and_stop();
   end
endmodule
`default_nettype wire
